// ### verilog/acicr_pkg.sv
// Package for the clock input configuration register bank.
// Assumes byte-wide register access from the serial control port decoder.
package acicr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CLOCK_INPUT_CONTROL_OFS = 8'h2a;
	localparam logic [7:0] SYSREF_EDGE_POSITION_OFS = 8'h2c;
	localparam logic [7:0] FULL_SCALE_CODE_OFS = 8'h30;
	localparam logic [7:0] POWER_MODE_FIRST_OFS = 8'h37;
	localparam logic [7:0] TIMESTAMP_INPUT_CONTROL_OFS = 8'h3b;
	localparam logic [7:0] REFERENCE_OUTPUT_CONTROL_OFS = 8'h3c;
	localparam logic [7:0] CLOCK_INPUT_CONTROL_RST = 8'h00;
	localparam logic [23:0] SYSREF_EDGE_POSITION_RST = 24'h000000;
	localparam logic [15:0] FULL_SCALE_CODE_RST = 16'ha000;
	localparam logic [7:0] POWER_MODE_FIRST_RST = 8'h4b;
	localparam logic [7:0] TIMESTAMP_INPUT_CONTROL_RST = 8'h00;
	localparam logic [7:0] REFERENCE_OUTPUT_CONTROL_RST = 8'h01;
	localparam int SAMPLE_CLOCK_PECL_BIT = 2;
	localparam int SYSREF_PECL_BIT = 1;
	localparam int SYSREF_FLIP_BIT = 0;
	localparam int TIMESTAMP_PECL_BIT = 1;
	localparam int TIMESTAMP_RECV_BIT = 0;
	localparam int REF_OUT_ENABLE_BIT = 0;
	localparam logic [7:0] CLOCK_INPUT_CONTROL_MASK = 8'h07;
	localparam logic [7:0] TIMESTAMP_INPUT_CONTROL_MASK = 8'h03;
	localparam logic [7:0] REFERENCE_OUTPUT_CONTROL_MASK = 8'h01;
	localparam logic [7:0] POWER_MODE_LOW = 8'h46;
	localparam logic [7:0] POWER_MODE_HIGH = 8'h4b;
	localparam logic [15:0] FULL_SCALE_MIN_GOOD = 16'h2000;
	typedef enum logic [1:0] {ACICR_PM_HIGH, ACICR_PM_LOW, ACICR_PM_RESERVED} acicr_power_mode_t;
endpackage : acicr_pkg

// ### verilog/acicr_byte_lane.sv
// One byte-wide configuration byte with write mask and reset value.
// Assumes write strobe and data synchronous to clock.
`timescale 1ns/1ps
module acicr_byte_lane #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'hff
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic writeStrobe,
	input wire logic [7:0] writeData,
	output logic [7:0] value
);
	logic [7:0] value_reg;
	logic [7:0] value_next;

	always_comb begin
		value_next = value_reg;
		if (writeStrobe && clockEnable)
			value_next = writeData & WRITE_MASK;
	end

	always_ff @(posedge clock) begin
		if (reset)
			value_reg <= RESET_VALUE;
		else
			value_reg <= value_next;
	end

	assign value = value_reg;
endmodule : acicr_byte_lane

// ### verilog/acicr_regs.sv
// Clock input configuration register bank of a multi-channel converter.
// Assumes the serial control port delivers byte strobes with an 8-bit address.
// Function
// - Bit 2 of clock input control puts the sample clock input in PECL mode.
// - Bit 1 of clock input control puts the SYSREF input in PECL mode.
// - Bit 0 of clock input control inverts SYSREF before alignment use.
// - A 24-bit status field reports the captured SYSREF edge position.
// - A 16-bit full-scale code serves all channels, resetting to 0xa000.
// - The power mode code accepts 0x46 for low power and 0x4b for high performance.
// - Bit 1 of timestamp control puts the timestamp input in PECL mode.
// - The timestamp receiver is enabled only while bit 0 of timestamp control is set.
// - The reference clock output runs while its enable and the PLL enable are set.
// - The reference output enable resets to 1, register value 0x01.
`timescale 1ns/1ps
module acicr_regs #(
	parameter int POSITION_W = 24,
	parameter int RANGE_W = 16
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	input wire logic [7:0] address,
	input wire logic [7:0] writeData,
	output logic [7:0] readData,
	output logic readValid,
	input wire logic [POSITION_W-1:0] sysrefEdgePosition,
	input wire logic sysrefIn,
	input wire logic pllEnable,
	output logic samplePeclMode,
	output logic sysrefPeclMode,
	output logic sysrefAligned,
	output logic [RANGE_W-1:0] fullScaleCode,
	output logic lowPowerMode,
	output logic powerModeReserved,
	output logic rangeDegraded,
	output logic timestampPeclMode,
	output logic timestampReceiverEnable,
	output logic referenceClockEnable
);
	// The byte map below serves exactly these widths
	if (POSITION_W != 24 || RANGE_W != 16) begin : g_bad_widths
		$error("acicr_regs: widths must be 24 and 16");
	end

	logic [7:0] clockCtl;
	logic [7:0] powerCode;
	logic [7:0] stampCtl;
	logic [7:0] refCtl;
	logic [7:0] rangeLo;
	logic [7:0] rangeHi;
	logic [7:0] readByte;
	logic [7:0] readData_reg;
	logic [7:0] readData_next;
	logic readValid_reg;
	logic readValid_next;
	logic [POSITION_W-1:0] position_reg;
	logic [POSITION_W-1:0] position_next;
	logic sysrefAligned_reg;
	logic sysrefAligned_next;
	logic writeClock;
	logic writePower;
	logic writeStamp;
	logic writeRef;
	logic writeRangeLo;
	logic writeRangeHi;
	acicr_pkg::acicr_power_mode_t powerMode;

	// Byte-addressed: full-scale low byte at base, high byte at base+1
	assign writeClock = writeStrobe && address == acicr_pkg::CLOCK_INPUT_CONTROL_OFS;
	assign writePower = writeStrobe && address == acicr_pkg::POWER_MODE_FIRST_OFS;
	assign writeStamp = writeStrobe && address == acicr_pkg::TIMESTAMP_INPUT_CONTROL_OFS;
	assign writeRef = writeStrobe && address == acicr_pkg::REFERENCE_OUTPUT_CONTROL_OFS;
	assign writeRangeLo = writeStrobe && address == acicr_pkg::FULL_SCALE_CODE_OFS;
	assign writeRangeHi = writeStrobe && address == acicr_pkg::FULL_SCALE_CODE_OFS + 8'h01;

	// Reserved bits are held at zero whatever software writes
	acicr_byte_lane #(.RESET_VALUE(acicr_pkg::CLOCK_INPUT_CONTROL_RST),
		.WRITE_MASK(acicr_pkg::CLOCK_INPUT_CONTROL_MASK)) clockLane (
		.clock(clock), .reset(reset), .clockEnable(clockEnable),
		.writeStrobe(writeClock), .writeData(writeData), .value(clockCtl));
	acicr_byte_lane #(.RESET_VALUE(acicr_pkg::POWER_MODE_FIRST_RST)) powerLane (
		.clock(clock), .reset(reset), .clockEnable(clockEnable),
		.writeStrobe(writePower), .writeData(writeData), .value(powerCode));
	acicr_byte_lane #(.RESET_VALUE(acicr_pkg::TIMESTAMP_INPUT_CONTROL_RST),
		.WRITE_MASK(acicr_pkg::TIMESTAMP_INPUT_CONTROL_MASK)) stampLane (
		.clock(clock), .reset(reset), .clockEnable(clockEnable),
		.writeStrobe(writeStamp), .writeData(writeData), .value(stampCtl));
	acicr_byte_lane #(.RESET_VALUE(acicr_pkg::REFERENCE_OUTPUT_CONTROL_RST),
		.WRITE_MASK(acicr_pkg::REFERENCE_OUTPUT_CONTROL_MASK)) refLane (
		.clock(clock), .reset(reset), .clockEnable(clockEnable),
		.writeStrobe(writeRef), .writeData(writeData), .value(refCtl));
	acicr_byte_lane #(.RESET_VALUE(acicr_pkg::FULL_SCALE_CODE_RST[7:0])) rangeLoLane (
		.clock(clock), .reset(reset), .clockEnable(clockEnable),
		.writeStrobe(writeRangeLo), .writeData(writeData), .value(rangeLo));
	acicr_byte_lane #(.RESET_VALUE(acicr_pkg::FULL_SCALE_CODE_RST[15:8])) rangeHiLane (
		.clock(clock), .reset(reset), .clockEnable(clockEnable),
		.writeStrobe(writeRangeHi), .writeData(writeData), .value(rangeHi));

	always_comb begin
		unique case (powerCode)
			acicr_pkg::POWER_MODE_HIGH: powerMode = acicr_pkg::ACICR_PM_HIGH;
			acicr_pkg::POWER_MODE_LOW: powerMode = acicr_pkg::ACICR_PM_LOW;
			default: powerMode = acicr_pkg::ACICR_PM_RESERVED;
		endcase
	end

	// Controls follow the stored fields directly, except that pllEnable also gates the reference clock enable
	assign samplePeclMode = clockCtl[acicr_pkg::SAMPLE_CLOCK_PECL_BIT];
	assign sysrefPeclMode = clockCtl[acicr_pkg::SYSREF_PECL_BIT];
	assign fullScaleCode = {rangeHi, rangeLo};
	assign rangeDegraded = fullScaleCode < acicr_pkg::FULL_SCALE_MIN_GOOD;
	assign lowPowerMode = powerMode == acicr_pkg::ACICR_PM_LOW;
	assign powerModeReserved = powerMode == acicr_pkg::ACICR_PM_RESERVED;
	assign timestampPeclMode = stampCtl[acicr_pkg::TIMESTAMP_PECL_BIT];
	assign timestampReceiverEnable = stampCtl[acicr_pkg::TIMESTAMP_RECV_BIT];
	assign referenceClockEnable = refCtl[acicr_pkg::REF_OUT_ENABLE_BIT] & pllEnable;
	assign sysrefAligned = sysrefAligned_reg;
	assign readData = readData_reg;
	assign readValid = readValid_reg;

	// Unmapped addresses read as zero
	always_comb begin
		readByte = 8'h00;
		unique case (address)
			acicr_pkg::CLOCK_INPUT_CONTROL_OFS: readByte = clockCtl;
			acicr_pkg::SYSREF_EDGE_POSITION_OFS: readByte = position_reg[7:0];
			acicr_pkg::SYSREF_EDGE_POSITION_OFS + 8'h01: readByte = position_reg[15:8];
			acicr_pkg::SYSREF_EDGE_POSITION_OFS + 8'h02: readByte = position_reg[23:16];
			acicr_pkg::FULL_SCALE_CODE_OFS: readByte = rangeLo;
			acicr_pkg::FULL_SCALE_CODE_OFS + 8'h01: readByte = rangeHi;
			acicr_pkg::POWER_MODE_FIRST_OFS: readByte = powerCode;
			acicr_pkg::TIMESTAMP_INPUT_CONTROL_OFS: readByte = stampCtl;
			acicr_pkg::REFERENCE_OUTPUT_CONTROL_OFS: readByte = refCtl;
			default: readByte = 8'h00;
		endcase
	end

	// Read port, position capture and SYSREF polarity all hold while clockEnable is low
	always_comb begin
		readData_next = readData_reg;
		readValid_next = readValid_reg;
		position_next = position_reg;
		sysrefAligned_next = sysrefAligned_reg;
		if (clockEnable) begin
			readValid_next = readStrobe;
			if (readStrobe)
				readData_next = readByte;
			position_next = sysrefEdgePosition;
			sysrefAligned_next = sysrefIn ^ clockCtl[acicr_pkg::SYSREF_FLIP_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			readData_reg <= 8'h00;
			readValid_reg <= 1'b0;
			position_reg <= acicr_pkg::SYSREF_EDGE_POSITION_RST;
			sysrefAligned_reg <= 1'b0;
		end else begin
			readData_reg <= readData_next;
			readValid_reg <= readValid_next;
			position_reg <= position_next;
			sysrefAligned_reg <= sysrefAligned_next;
		end
	end

	// Multi-step register traffic that the read-back checks start from
	sequence s_position_read;
		clockEnable ##1 clockEnable && readStrobe && address == acicr_pkg::SYSREF_EDGE_POSITION_OFS;
	endsequence
	sequence s_ref_write_read;
		clockEnable && writeRef ##1 clockEnable && readStrobe && address == acicr_pkg::REFERENCE_OUTPUT_CONTROL_OFS;
	endsequence

	a_flip_polarity: assert property (@(posedge clock) disable iff (reset)
		clockEnable |=> sysrefAligned == ($past(sysrefIn) ^ $past(clockCtl[acicr_pkg::SYSREF_FLIP_BIT])))
		else $error("sysref polarity wrong");
	a_sample_pecl: assert property (@(posedge clock) disable iff (reset)
		clockEnable && writeClock |=> samplePeclMode == $past(writeData[2]))
		else $error("sample clock pecl mode wrong");
	a_sysref_pecl: assert property (@(posedge clock) disable iff (reset)
		clockEnable && writeClock |=> sysrefPeclMode == $past(writeData[1]))
		else $error("sysref pecl mode wrong");
	a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
		clockCtl[7:3] == 5'h00) else $error("reserved clock bits set");
	a_position_report: assert property (@(posedge clock) disable iff (reset)
		s_position_read |=> readData == $past(sysrefEdgePosition[7:0], 2)) else $error("position byte wrong");
	a_range_reset: assert property (@(posedge clock)
		$past(reset) && reset |-> fullScaleCode == acicr_pkg::FULL_SCALE_CODE_RST)
		else $error("full scale reset wrong");
	a_range_store: assert property (@(posedge clock) disable iff (reset)
		clockEnable && writeRangeHi |=> fullScaleCode[15:8] == $past(writeData))
		else $error("full scale high byte wrong");
	a_power_decode: assert property (@(posedge clock) disable iff (reset)
		lowPowerMode |-> powerCode == acicr_pkg::POWER_MODE_LOW && !powerModeReserved)
		else $error("power decode wrong");
	a_power_store: assert property (@(posedge clock) disable iff (reset)
		clockEnable && writePower |=> powerCode == $past(writeData))
		else $error("power mode code not stored");
	a_stamp_recv: assert property (@(posedge clock) disable iff (reset)
		clockEnable && writeStamp |=> timestampReceiverEnable == $past(writeData[0]))
		else $error("timestamp receiver enable wrong");
	a_stamp_pecl: assert property (@(posedge clock) disable iff (reset)
		clockEnable && writeStamp |=> timestampPeclMode == $past(writeData[1]))
		else $error("timestamp pecl mode wrong");
	a_ref_output: assert property (@(posedge clock) disable iff (reset)
		referenceClockEnable == (refCtl[0] && pllEnable)) else $error("reference output wrong");
	a_ref_reset: assert property (@(posedge clock)
		$past(reset) && reset |-> refCtl == acicr_pkg::REFERENCE_OUTPUT_CONTROL_RST)
		else $error("reference enable reset wrong");
	a_read_back: assert property (@(posedge clock) disable iff (reset)
		s_ref_write_read |=> readData == {7'h00, $past(writeData[0], 2)}) else $error("read back wrong");
	a_read_valid: assert property (@(posedge clock) disable iff (reset)
		clockEnable |=> readValid == $past(readStrobe)) else $error("read valid wrong");
	// A frozen cycle must leave clock control, reference control, readValid and sysrefAligned as they were
	a_freeze_hold: assert property (@(posedge clock) disable iff (reset)
		!clockEnable |=> $stable(clockCtl) && $stable(refCtl) && $stable(readValid) && $stable(sysrefAligned))
		else $error("state moved while frozen");
endmodule : acicr_regs

// ### tb/acicr_regs_tb_top.sv
// Self-checking bench for the clock input configuration register bank.
// Assumes the bench alone drives the byte port, changing inputs at the falling edge.
`timescale 1ns/1ps
module acicr_regs_tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic clockEnable = 1'b1;
	logic writeStrobe = 1'b0;
	logic readStrobe = 1'b0;
	logic [7:0] address = 8'h00;
	logic [7:0] writeData = 8'h00;
	logic [23:0] sysrefEdgePosition = 24'h000000;
	logic sysrefIn = 1'b0;
	logic pllEnable = 1'b1;
	logic [7:0] readData;
	logic readValid, samplePeclMode, sysrefPeclMode, sysrefAligned, lowPowerMode, powerModeReserved;
	logic rangeDegraded, timestampPeclMode, timestampReceiverEnable, referenceClockEnable;
	logic [15:0] fullScaleCode;
	int n_mismatch = 0;
	int compares = 0;
	// Rows: address, written byte, byte read back
	logic [23:0] rows [9] = '{24'h2aff07, 24'h2a0505, 24'h3bfe02, 24'h3b0101, 24'h3cfe00,
		24'h300000, 24'h312020, 24'h374646, 24'h505a00};
	// Rows: address, value after reset
	logic [15:0] rstRows [7] = '{16'h2a00, 16'h2c00, 16'h3000, 16'h31a0, 16'h374b, 16'h3b00, 16'h3c01};
	acicr_regs uut (.clock(clock), .reset(reset), .clockEnable(clockEnable), .writeStrobe(writeStrobe),
		.readStrobe(readStrobe), .address(address), .writeData(writeData), .readData(readData),
		.readValid(readValid), .sysrefEdgePosition(sysrefEdgePosition), .sysrefIn(sysrefIn),
		.pllEnable(pllEnable), .samplePeclMode(samplePeclMode), .sysrefPeclMode(sysrefPeclMode),
		.sysrefAligned(sysrefAligned), .fullScaleCode(fullScaleCode), .lowPowerMode(lowPowerMode),
		.powerModeReserved(powerModeReserved), .rangeDegraded(rangeDegraded),
		.timestampPeclMode(timestampPeclMode), .timestampReceiverEnable(timestampReceiverEnable),
		.referenceClockEnable(referenceClockEnable));
	initial begin
		forever #10 clock = ~clock;
	end
	task automatic final_report();
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		address = a;
		writeData = d;
		writeStrobe = 1'b1;
		@(negedge clock);
		writeStrobe = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		int i;
		address = a;
		readStrobe = 1'b1;
		@(negedge clock);
		readStrobe = 1'b0;
		for (i = 0; i < 4 && readValid !== 1'b1; i++)
			@(negedge clock);
		if (i == 4) begin
			n_mismatch++;
			final_report();
		end else begin
			chk(16'(readData), 16'(e));
			@(negedge clock);
		end
	endtask : rd
	initial begin
		repeat (16) @(negedge clock);
		reset = 1'b0;
		foreach (rstRows[k]) rd(rstRows[k][15:8], rstRows[k][7:0]);
		chk(16'(referenceClockEnable), 16'h0001);
		foreach (rows[k]) begin
			wr(rows[k][23:16], rows[k][15:8]);
			rd(rows[k][23:16], rows[k][7:0]);
		end
		// Fields now: clock 0x05, timestamp 0x01, reference 0x00, full scale 0x2000, power 0x46
		chk(16'({samplePeclMode, sysrefPeclMode, timestampPeclMode, timestampReceiverEnable}), 16'h0009);
		chk({lowPowerMode, powerModeReserved, rangeDegraded, 13'h0}, 16'h8000);
		chk(fullScaleCode, 16'h2000);
		chk(16'(referenceClockEnable), 16'h0000);
		sysrefIn = 1'b1;
		repeat (2) @(negedge clock);
		chk(16'(sysrefAligned), 16'h0000);
		wr(8'h2a, 8'h04);
		@(negedge clock);
		chk(16'(sysrefAligned), 16'h0001);
		chk(16'({samplePeclMode, sysrefPeclMode}), 16'h0002);
		wr(8'h3c, 8'h01);
		chk(16'(referenceClockEnable), 16'h0001);
		pllEnable = 1'b0;
		@(negedge clock);
		chk(16'(referenceClockEnable), 16'h0000);
		wr(8'h37, 8'h47);
		chk(16'({lowPowerMode, powerModeReserved}), 16'h0001);
		@(negedge clock);
		wr(8'h37, 8'h4b);
		chk(16'({lowPowerMode, powerModeReserved}), 16'h0000);
		@(negedge clock);
		wr(8'h31, 8'h1f);
		chk(16'(rangeDegraded), 16'h0001);
		@(negedge clock);
		wr(8'h2c, 8'h11);
		sysrefEdgePosition = 24'ha5c33c;
		repeat (2) @(negedge clock);
		rd(8'h2c, 8'h3c);
		rd(8'h2d, 8'hc3);
		rd(8'h2e, 8'ha5);
		clockEnable = 1'b0;
		wr(8'h2a, 8'h03);
		clockEnable = 1'b1;
		rd(8'h2a, 8'h04);
		reset = 1'b1;
		@(negedge clock);
		reset = 1'b0;
		chk(fullScaleCode, 16'ha000);
		rd(8'h3c, 8'h01);
		rd(8'h2a, 8'h00);
		final_report();
	end
endmodule : acicr_regs_tb_top
